/* inc/ustf_pkg.sv */
// Shared constants and carrier types of the UDP stream transfer framer.
package ustf_pkg;

  // ----------------------------------------------------------------
  // Header field values
  // ----------------------------------------------------------------
  localparam logic [3:0]  USTF_VERSION  = 4'h1;
  localparam logic [3:0]  USTF_MSG_FULL = 4'h0;
  localparam logic [3:0]  USTF_MSG_SEG  = 4'h1;
  localparam logic [7:0]  USTF_RSV_VAL  = 8'h00;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] USTF_SEQ_RST  = 24'h000000;
  localparam logic [31:0] USTF_OFS_RST  = 32'h00000000;
  localparam logic [13:0] USTF_CNT_RST  = 14'h0000;

  // ----------------------------------------------------------------
  // Length limits in bytes, and the fragment size in words
  // ----------------------------------------------------------------
  // The datagram payload must stay strictly below this figure under IPv4.
  localparam int unsigned USTF_MAX_MSG_BYTES  = 32726;
  localparam int unsigned USTF_HDR_FULL_BYTES = 4;
  localparam int unsigned USTF_HDR_SEG_BYTES  = 12;
  localparam logic [31:0] USTF_FULL_LIMIT     =
    32'(USTF_MAX_MSG_BYTES - USTF_HDR_FULL_BYTES);
  // Largest whole number of data words that keeps a segmented datagram legal.
  localparam logic [13:0] USTF_SEG_WORDS      =
    14'((USTF_MAX_MSG_BYTES - 1 - USTF_HDR_SEG_BYTES) / 4);
  localparam logic [31:0] USTF_SEG_BYTES      = 32'(USTF_SEG_WORDS) << 2;
  localparam logic [13:0] USTF_SEG_LAST       = USTF_SEG_WORDS - 14'h0001;

  // ----------------------------------------------------------------
  // Carrier types and sequencer states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] data;
    logic        sop;
    logic        eop;
  } ustf_word_t;

  typedef struct packed {
    logic [31:0] len;
    logic [15:0] chan_id;
    logic [7:0]  chan_seq;
  } ustf_pkt_info_t;

  typedef enum {
    USTF_IDLE,
    USTF_HDR0,
    USTF_HDR1,
    USTF_HDR2,
    USTF_DATA
  } ustf_state_t;

endpackage

/* hdl/ustf_buf.sv */
// Two-entry buffer with valid and ready on both sides and registered outputs.
`timescale 1ns/1ps
module ustf_buf #(
  parameter int W = 34
) (
  input  wire logic         clk,        // System clock.
  input  wire logic         rst_n,      // Synchronous reset, active low.
  input  wire logic         up_valid,   // Word offered by the framer.
  output logic              up_ready,   // Room for at least one word.
  input  wire logic [W-1:0] up_data,    // Offered word.
  output logic              dn_valid,   // Head word present.
  input  wire logic         dn_ready,   // Receiver takes the head word.
  output logic [W-1:0]      dn_data     // Head word.
);

  logic [W-1:0] tail_q;
  logic [1:0]   cnt_q;
  logic [1:0]   cnt_d;
  logic         push;
  logic         pop;

  assign push = up_valid && up_ready;
  assign pop  = dn_valid && dn_ready;

  always_comb
  begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + 2'h1;
    else if (pop && !push)
      cnt_d = cnt_q - 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q    <= 2'h0;
      dn_valid <= 1'b0;
      up_ready <= 1'b0;
    end
    else
    begin
      cnt_q    <= cnt_d;
      dn_valid <= (cnt_d != 2'h0);
      up_ready <= (cnt_d != 2'h2);
    end
  end

  // Data registers need no reset; the valid flag guards them.
  always_ff @(posedge clk)
  begin
    if (pop)
    begin
      if (cnt_q == 2'h2)
        dn_data <= tail_q;
      else if (push)
        dn_data <= up_data;
      if (push && cnt_q == 2'h2)
        tail_q <= up_data;
    end
    else if (push)
    begin
      if (cnt_q == 2'h0)
        dn_data <= up_data;
      else
        tail_q <= up_data;
    end
  end

endmodule

/* hdl/ustf_framer.sv */
// UDP stream transfer framer: prefixes recorder packets with transfer headers.
`timescale 1ns/1ps
module ustf_framer
(
  input  wire logic                     ref_clk,   // System clock, 40 MHz.
  input  wire logic                     rst_n,     // Synchronous reset, active low.
  input  wire logic                     in_valid,  // Source offers a packet word.
  output logic                          in_ready,  // Framer takes the word.
  input  wire ustf_pkg::ustf_word_t     in_word,   // Packet word with start/end marks.
  input  wire ustf_pkg::ustf_pkt_info_t in_info,   // Packet facts, valid with start word.
  output logic                          out_valid, // Datagram word present.
  input  wire logic                     out_ready, // Receiver takes the word.
  output ustf_pkg::ustf_word_t          out_word   // Datagram word with start/end marks.
);

  import ustf_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ustf_state_t state_q;
  logic [23:0] seq_q;
  logic        seg_mode_q;
  logic [15:0] chan_id_q;
  logic [7:0]  chan_seq_q;
  logic [31:0] offset_q;
  logic [13:0] seg_cnt_q;

  logic        buf_valid;
  logic        buf_ready;
  ustf_word_t  buf_word;
  logic        take;
  logic        seg_end;
  logic        start_seen;

  assign take       = buf_valid && buf_ready;
  assign start_seen = in_valid && in_word.sop;
  // A fragment closes once it holds the largest legal number of words.
  assign seg_end    = seg_mode_q && (seg_cnt_q == USTF_SEG_LAST);

  // ----------------------------------------------------------------
  // Datagram word selection
  // ----------------------------------------------------------------
  always_comb
  begin
    buf_valid = 1'b0;
    buf_word  = '0;
    in_ready  = 1'b0;
    case (state_q)
      USTF_IDLE:
      begin
        // Stray words outside a packet are dropped; a start word waits.
        in_ready = !start_seen;
      end
      USTF_HDR0:
      begin
        buf_valid     = 1'b1;
        buf_word.sop  = 1'b1;
        buf_word.data = {seq_q,
                         seg_mode_q ? USTF_MSG_SEG : USTF_MSG_FULL,
                         USTF_VERSION};
      end
      USTF_HDR1:
      begin
        buf_valid     = 1'b1;
        buf_word.data = {USTF_RSV_VAL, chan_seq_q, chan_id_q};
      end
      USTF_HDR2:
      begin
        buf_valid     = 1'b1;
        buf_word.data = offset_q;
      end
      USTF_DATA:
      begin
        // Words pass unchanged, so the stored byte order is kept.
        buf_valid     = in_valid;
        buf_word.data = in_word.data;
        buf_word.eop  = in_word.eop || seg_end;
        in_ready      = buf_ready;
      end
      default:
      begin
        buf_valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      state_q <= USTF_IDLE;
    else
    begin
      case (state_q)
        USTF_IDLE:
          if (start_seen)
            state_q <= USTF_HDR0;
        USTF_HDR0:
          if (take)
            state_q <= seg_mode_q ? USTF_HDR1 : USTF_DATA;
        USTF_HDR1:
          if (take)
            state_q <= USTF_HDR2;
        USTF_HDR2:
          if (take)
            state_q <= USTF_DATA;
        USTF_DATA:
          if (take)
          begin
            // One whole packet per short-header datagram keeps it integral.
            if (in_word.eop)
              state_q <= USTF_IDLE;
            else if (seg_end)
              state_q <= USTF_HDR0;
          end
        default:
          state_q <= USTF_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Datagram sequence number
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      seq_q <= USTF_SEQ_RST;
    else if (state_q == USTF_HDR0 && take)
      seq_q <= seq_q + 24'h000001;
  end

  // ----------------------------------------------------------------
  // Packet facts and framing choice
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      seg_mode_q <= 1'b0;
      chan_id_q  <= 16'h0000;
      chan_seq_q <= 8'h00;
    end
    else if (state_q == USTF_IDLE && start_seen)
    begin
      // Whole framing only while packet plus short header stays legal.
      seg_mode_q <= !(in_info.len < USTF_FULL_LIMIT);
      chan_id_q  <= in_info.chan_id;
      chan_seq_q <= in_info.chan_seq;
    end
  end

  // ----------------------------------------------------------------
  // Segment offset and fragment word count
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      offset_q  <= USTF_OFS_RST;
      seg_cnt_q <= USTF_CNT_RST;
    end
    else if (state_q == USTF_IDLE)
    begin
      offset_q  <= USTF_OFS_RST;
      seg_cnt_q <= USTF_CNT_RST;
    end
    else if (state_q == USTF_DATA && take)
    begin
      if (seg_end)
      begin
        offset_q  <= offset_q + USTF_SEG_BYTES;
        seg_cnt_q <= USTF_CNT_RST;
      end
      else
        seg_cnt_q <= seg_cnt_q + 14'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  // A stall by the receiver backs up into the sequencer, never drops a word.
  ustf_buf #(
    .W ($bits(ustf_word_t))
  ) u_buf (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .up_valid (buf_valid),
    .up_ready (buf_ready),
    .up_data  (buf_word),
    .dn_valid (out_valid),
    .dn_ready (out_ready),
    .dn_data  (out_word)
  );

endmodule

/* sim/ustf_framer_properties.sv */
// Port checks for the UDP stream transfer framer.
`timescale 1ns/1ps
module ustf_framer_properties
  import ustf_pkg::*;
(
  input wire logic                     ref_clk,   // Clock.
  input wire logic                     rst_n,     // Reset.
  input wire logic                     in_valid,  // Offer in.
  input wire logic                     in_ready,  // Take in.
  input wire ustf_pkg::ustf_word_t     in_word,   // Word in.
  input wire ustf_pkg::ustf_pkt_info_t in_info,   // Facts in.
  input wire logic                     out_valid, // Offer out.
  input wire logic                     out_ready, // Take out.
  input wire ustf_pkg::ustf_word_t     out_word   // Word out.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic        take;
  logic        open_q;
  logic        seg_q;
  logic        seen_q;
  logic [23:0] seq_q;
  logic [13:0] cnt_q;
  assign take = out_valid && out_ready;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      open_q <= 1'b0;
      seen_q <= 1'b0;
      seg_q  <= 1'b0;
      seq_q  <= 24'h000000;
      cnt_q  <= 14'h0000;
    end
    else if (take)
    begin
      open_q <= !out_word.eop;
      cnt_q  <= out_word.eop ? 14'h0000 : cnt_q + 14'h0001;
      seen_q <= seen_q || out_word.sop;
      if (out_word.sop)
      begin
        seq_q <= out_word.data[31:8];
        seg_q <= out_word.data[7:4] == 4'h1;
      end
    end
  end
  sequence s_start;
    take && out_word.sop;
  endsequence
  sequence s_rsv;
    out_valid && seg_q && cnt_q == 14'h0001;
  endsequence
  chk_version_one: assert property (s_start |-> out_word.data[3:0] == 4'h1)
    else $error("version not one");
  chk_type_known: assert property (s_start |-> out_word.data[7:4] inside {4'h0, 4'h1})
    else $error("reserved type");
  chk_stall_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("word lost in stall");
  chk_sop_first: assert property (out_valid |-> out_word.sop == !open_q)
    else $error("start mark misplaced");
  chk_seq_step: assert property (s_start |->
    out_word.data[31:8] == (seen_q ? seq_q + 24'h000001 : 24'h000000))
    else $error("sequence skipped");
  chk_len_cap: assert property (take |-> cnt_q < 14'h1ff5)
    else $error("datagram too long");
  chk_rsv_zero: assert property (s_rsv |-> out_word.data[31:24] == 8'h00)
    else $error("reserved byte set");
  chk_hdr_gap: assert property (in_valid && in_ready && in_word.sop |-> !$past(in_ready))
    else $error("no header gap");
endmodule

bind ustf_framer ustf_framer_properties i_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready),
  .in_word(in_word), .in_info(in_info), .out_valid(out_valid),
  .out_ready(out_ready), .out_word(out_word));

/* sim/ustf_rx_model.sv */
// Subscriber model: collects datagram words, stalling on request.
`timescale 1ns/1ps
module ustf_rx_model
  import ustf_pkg::*;
(
  input  wire logic                 ref_clk,   // Clock.
  input  wire logic                 rst_n,     // Reset.
  input  wire logic                 slow,      // Stall every other cycle.
  input  wire logic                 out_valid, // Word offered.
  output logic                      out_ready, // Word taken.
  input  wire ustf_pkg::ustf_word_t out_word   // Offered word.
);
  ustf_word_t got[$];
  logic       tgl;
  initial
  begin
    out_ready = 1'b0;
    tgl       = 1'b0;
  end
  // Ready moves on the falling edge so it never races the sampling edge.
  always @(negedge ref_clk)
  begin
    tgl       = !tgl;
    out_ready = rst_n && (!slow || tgl);
  end
  always @(posedge ref_clk)
    if (rst_n && out_valid && out_ready)
      got.push_back(out_word);
endmodule

/* sim/ustf_framer_test.sv */
// Self-checking bench for the UDP stream transfer framer.
`timescale 1ns/1ps
module ustf_framer_test;
  import ustf_pkg::*;
  logic           ref_clk, rst_n, in_valid, in_ready, out_valid, out_ready, slow;
  ustf_word_t     in_word, out_word;
  ustf_pkt_info_t in_info;
  int             mismatches, samples_checked;
  logic [23:0]    seq_exp;
  ustf_framer i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .in_valid(in_valid),
    .in_ready(in_ready), .in_word(in_word), .in_info(in_info),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));
  ustf_rx_model i_rx (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word));
  always #12.5 ref_clk = !ref_clk;
  task automatic results;
    $display("mismatches %0d, samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string nm, input ustf_word_t e, input ustf_word_t g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_n(input string nm, input int e, input int g);
    samples_checked++;
    if (g != e)
    begin
      mismatches++;
      $display("unexpected %s: expected %0d, seen %0d", nm, e, g);
    end
  endtask
  // Offers a word and leaves the valid raised; the caller lowers it.
  task automatic put(input logic [31:0] d, input logic s, input logic e);
    int n;
    in_valid = 1'b1;
    in_word  = '{data: d, sop: s, eop: e};
    // Ready is judged at the rising edge, where the framer itself samples it.
    @(posedge ref_clk);
    for (n = 0; n < 50 && in_ready !== 1'b1; n++)
      @(posedge ref_clk);
    if (n == 50)
      cmp_n("input ready wait", 1, 0);
    @(negedge ref_clk);
  endtask
  task automatic frame(input int nw, input logic [15:0] cid, input logic [7:0] cs);
    int seg, tot, k, n, w, p;
    seg = nw * 4 >= 32722;
    tot = seg ? nw + 3 * ((nw + 8177) / 8178) : nw + 1;
    in_info = '{len: 32'(nw * 4), chan_id: cid, chan_seq: cs};
    for (k = 0; k < nw; k++)
      put({cid, 16'(k)}, k == 0, k == nw - 1);
    in_valid = 1'b0;
    for (n = 0; n < 200 && i_rx.got.size() < tot; n++)
      @(negedge ref_clk);
    cmp_n("word count", tot, i_rx.got.size());
    p = 0;
    k = 0;
    while (p < tot && i_rx.got.size() == tot)
    begin
      cmp("header", '{{seq_exp, 3'h0, seg[0], 4'h1}, 1'b1, 1'b0}, i_rx.got[p]);
      seq_exp++;
      p++;
      if (seg)
      begin
        cmp("channel", '{{8'h00, cs, cid}, 1'b0, 1'b0}, i_rx.got[p]);
        cmp("offset", '{32'(k * 4), 1'b0, 1'b0}, i_rx.got[p + 1]);
        p += 2;
      end
      for (w = 0; w < (seg ? 8178 : nw) && k < nw; w++)
      begin
        cmp("data", '{{cid, 16'(k)}, 1'b0, (seg && w == 8177) || k == nw - 1},
            i_rx.got[p]);
        p++;
        k++;
      end
    end
    i_rx.got.delete();
  endtask
  task automatic t_single;
    slow = 1'b0;
    frame(1, 16'h0a01, 8'h05);
  endtask
  // A stray word outside a packet must vanish, then two packets run under stalls.
  task automatic t_stall;
    slow = 1'b1;
    put(32'h5a5a5a5a, 1'b0, 1'b0);
    frame(2, 16'h0b02, 8'h11);
    frame(5, 16'h0b03, 8'h12);
  endtask
  task automatic t_limit;
    slow = 1'b0;
    frame(8180, 16'h0c04, 8'hfe);
    frame(8181, 16'h0c05, 8'hff);
    frame(16357, 16'hffff, 8'h00);
  endtask
  initial
  begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    in_valid = 1'b0;
    in_word = '0;
    in_info = '0;
    slow = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    seq_exp = 24'h000000;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    t_single;
    t_stall;
    t_limit;
    results;
  end
  initial
  begin
    repeat (80000) @(posedge ref_clk);
    mismatches++;
    results;
  end
endmodule
